// ===== include/srd_pkg.sv
package srd_pkg;
   // per-port reset domain controls, active high
   typedef struct packed {
      logic regs;
      logic sticky;
      logic tl;
      logic dl;
      logic phy;
      logic hot_req;
   } srd_port_rst_t;

   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SW_RST_NS = 1000;
   localparam int unsigned SW_RST_CYC = (SW_RST_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BOOT_W = 16;
   localparam logic [BOOT_W-1:0] BOOT_RST = 16'h0000;
   localparam srd_port_rst_t PORT_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage

// ===== design/srd_sync.sv
`timescale 1ns/1ps
module srd_sync #(
   parameter int unsigned W = 1,
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= {W{RST_VAL}};
         q_o <= {W{RST_VAL}};
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end
endmodule

// ===== design/srd_reset_dist.sv
`timescale 1ns/1ps
module srd_reset_dist #(
   parameter int unsigned BOOT_W = srd_pkg::BOOT_W,
   parameter int unsigned SW_RST_CYC = srd_pkg::SW_RST_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ext_reset_n_i,
   input wire logic sw_reset_i,
   input wire logic ghot_all_i,
   input wire logic ghot_ds_i,
   input wire logic local_hot_b_i,
   input wire logic local_hot_c_i,
   input wire logic [BOOT_W-1:0] boot_cfg_i,
   output srd_pkg::srd_port_rst_t port_a_o,
   output srd_pkg::srd_port_rst_t port_b_o,
   output srd_pkg::srd_port_rst_t port_c_o,
   output logic core_rst_o,
   output logic core_flush_o,
   output logic fund_active_o,
   output logic cold_o,
   output logic [BOOT_W-1:0] boot_cfg_o
);
   // the stretch counter is 16 bits wide, so longer stretches are refused
   if (BOOT_W < 1 || BOOT_W > 64 || SW_RST_CYC < 1 || SW_RST_CYC > 65535) begin : g_bad_param
      $error("srd_reset_dist: unsupported parameter");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic rst_n;
   logic pin_n;
   logic [BOOT_W-1:0] boot_s;

   // async assert, synchronous release
   srd_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(1'b1),
      .q_o(rst_n)
   );

   // pin held asserted until synchronised
   srd_sync #(.W(1), .RST_VAL(1'b0)) u_pin_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(ext_reset_n_i),
      .q_o(pin_n)
   );

   // same depth as the pin sync, so the straps line up with its release
   srd_sync #(.W(BOOT_W), .RST_VAL(1'b0)) u_boot_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(boot_cfg_i),
      .q_o(boot_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic pin_n_d;
   logic [15:0] sw_cnt;
   logic power_up;
   logic next_pin_n_d;
   logic [15:0] next_sw_cnt;
   logic next_power_up;
   logic next_cold;
   logic [BOOT_W-1:0] next_boot;
   logic fund;

   always_comb begin
      next_pin_n_d = pin_n;
      next_sw_cnt = sw_cnt;
      // software reset stretch
      // a new pulse reloads the count, so back to back writes extend it
      if (sw_reset_i) begin
         next_sw_cnt = 16'(SW_RST_CYC);
      end else if (sw_cnt != 16'h0000) begin
         next_sw_cnt = sw_cnt - 16'h0001;
      end
      fund = !pin_n || (sw_cnt != 16'h0000);
      next_power_up = power_up;
      next_cold = cold_o;
      next_boot = boot_cfg_o;
      // edge detect resets low with the pin sync: no false fall at release
      // first pin reset after power-up is cold
      if (!pin_n && pin_n_d) begin
         next_cold = power_up;
         next_power_up = 1'b0;
      end else if (sw_reset_i) begin
         next_cold = 1'b0;
      end
      if (!pin_n) begin
         next_power_up = 1'b0;
      end
      if (pin_n && !pin_n_d) begin
         next_boot = boot_s;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         // power-on reset counts as the first, cold, fundamental reset
         pin_n_d <= 1'b0;
         sw_cnt <= 16'h0000;
         power_up <= 1'b1;
         cold_o <= 1'b1;
         boot_cfg_o <= BOOT_W'(srd_pkg::BOOT_RST);
      end else begin
         pin_n_d <= next_pin_n_d;
         sw_cnt <= next_sw_cnt;
         power_up <= next_power_up;
         cold_o <= next_cold;
         boot_cfg_o <= next_boot;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hot requests are only honoured outside a fundamental reset
   srd_pkg::srd_port_rst_t next_a;
   srd_pkg::srd_port_rst_t next_b;
   srd_pkg::srd_port_rst_t next_c;
   logic next_core_rst;
   logic next_core_flush;
   logic g_all;
   logic g_any;
   logic l_b;
   logic l_c;

   always_comb begin
      // gating keeps hot_req low for the whole fundamental reset
      g_all = ghot_all_i && !fund;
      g_any = (ghot_all_i || ghot_ds_i) && !fund;
      l_b = local_hot_b_i && !fund;
      l_c = local_hot_c_i && !fund;
      // hot resets leave the sticky domain alone
      next_a.sticky = fund;
      next_b.sticky = fund;
      next_c.sticky = fund;
      next_a.regs = fund || g_all;
      next_a.tl = fund || g_all;
      next_a.dl = fund || g_all;
      next_a.phy = fund || g_all;
      // upstream port has no downstream partner to reset
      next_a.hot_req = 1'b0;
      next_b.regs = fund || g_any;
      next_c.regs = fund || g_any;
      next_b.tl = fund || g_any;
      // port C transaction layer follows the same rule
      next_c.tl = fund || g_any;
      next_b.dl = fund || g_any || l_b;
      next_b.phy = fund || g_any || l_b;
      next_c.dl = fund || g_any || l_c;
      next_c.phy = fund || g_any || l_c;
      next_b.hot_req = g_any || l_b;
      next_c.hot_req = g_any || l_c;
      next_core_rst = fund || g_all;
      // an all-device reset wins over the downstream-only flush
      next_core_flush = ghot_ds_i && !ghot_all_i && !fund;
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         // every domain stays in reset until the pin is seen high
         port_a_o <= srd_pkg::PORT_RST;
         port_b_o <= srd_pkg::PORT_RST;
         port_c_o <= srd_pkg::PORT_RST;
         core_rst_o <= 1'b1;
         core_flush_o <= 1'b0;
         fund_active_o <= 1'b1;
      end else begin
         port_a_o <= next_a;
         port_b_o <= next_b;
         port_c_o <= next_c;
         core_rst_o <= next_core_rst;
         core_flush_o <= next_core_flush;
         fund_active_o <= fund;
      end
   end
endmodule

// ===== verif/srd_reset_dist_chk.sv
`timescale 1ns/1ps
module srd_reset_dist_chk (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ext_reset_n_i,
   input wire logic sw_reset_i,
   input wire logic ghot_all_i,
   input wire logic ghot_ds_i,
   input wire logic local_hot_b_i,
   input wire logic local_hot_c_i,
   input wire srd_pkg::srd_port_rst_t port_a_o,
   input wire srd_pkg::srd_port_rst_t port_b_o,
   input wire srd_pkg::srd_port_rst_t port_c_o,
   input wire logic core_rst_o,
   input wire logic core_flush_o,
   input wire logic fund_active_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   fund_all_a: assert property (fund_active_o |-> core_rst_o &&
      {port_a_o[5:1], port_b_o[5:1], port_c_o[5:1]} == 15'h7fff) else $error("fund domain");
   sticky_keep_a: assert property ({port_a_o.sticky, port_b_o.sticky, port_c_o.sticky} ==
      {3{fund_active_o}}) else $error("sticky");
   pin_warm_a: assert property ($fell(ext_reset_n_i) |-> ##[2:4] fund_active_o)
      else $error("pin fund");
   sw_fund_a: assert property (sw_reset_i |-> ##2 fund_active_o[*2])
      else $error("sw fund");
   a_layer_a: assert property (!fund_active_o |-> port_a_o.dl == $past(ghot_all_i))
      else $error("a layer");
   b_tl_a: assert property (!fund_active_o |->
      port_b_o.tl == $past(ghot_all_i | ghot_ds_i)) else $error("b tl");
   b_link_a: assert property (!fund_active_o |->
      port_b_o.dl == $past(ghot_all_i | ghot_ds_i | local_hot_b_i)) else $error("b link");
   c_link_a: assert property (!fund_active_o |->
      port_c_o.phy == $past(ghot_all_i | ghot_ds_i | local_hot_c_i)) else $error("c link");
   no_req_a: assert property (fund_active_o |-> !port_b_o.hot_req && !port_c_o.hot_req)
      else $error("hot req");
   flush_a: assert property (!fund_active_o |->
      core_flush_o == $past(ghot_ds_i & !ghot_all_i)) else $error("flush");
   core_all_a: assert property (!fund_active_o |-> core_rst_o == $past(ghot_all_i))
      else $error("core reset");
endmodule
bind srd_reset_dist srd_reset_dist_chk i_chk (.core_clk_i, .rst_n_i, .ext_reset_n_i, .sw_reset_i,
   .ghot_all_i, .ghot_ds_i, .local_hot_b_i, .local_hot_c_i, .port_a_o, .port_b_o, .port_c_o,
   .core_rst_o, .core_flush_o, .fund_active_o);

// ===== verif/srd_src_model.sv
`timescale 1ns/1ps
module srd_src_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [15:0] cfg_i,
   output logic ext_reset_n_o,
   output logic [15:0] boot_o
);
   int hold = 0;
   initial ext_reset_n_o = 1'b0;
   initial boot_o = 16'h0000;
   // pin follows the request; straps hold a while past release
   // posedge with nonblocking updates avoids racing the bench's negedge drive
   always @(posedge clk_i) begin
      ext_reset_n_o <= !req_i;
      hold <= req_i ? 0 : hold + 1;
      // straps toggle every cycle once hold time is over
      boot_o <= (hold < 8) ? cfg_i : ~boot_o;
   end
endmodule

// ===== verif/tb_switch_reset_distribution.sv
`timescale 1ns/1ps
module tb_switch_reset_distribution;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, req = 1'b1, sw_reset_i = 1'b0;
   logic ghot_all_i = 1'b0, ghot_ds_i = 1'b0, local_hot_b_i = 1'b0, local_hot_c_i = 1'b0;
   logic ext_reset_n_i, core_rst_o, core_flush_o, fund_active_o, cold_o;
   logic [15:0] cfg = 16'h0000, boot_cfg_i, boot_cfg_o;
   srd_pkg::srd_port_rst_t port_a_o, port_b_o, port_c_o;
   localparam int SW_CYC = 4;
   int bad_count = 0, num_checks = 0, seed = 32'h95d97d89, r, n;
   always #2.5 core_clk_i = ~core_clk_i;
   srd_src_model i_src (.clk_i(core_clk_i), .req_i(req), .cfg_i(cfg),
      .ext_reset_n_o(ext_reset_n_i), .boot_o(boot_cfg_i));
   srd_reset_dist #(.SW_RST_CYC(SW_CYC)) i_dut (.core_clk_i, .rst_n_i, .ext_reset_n_i, .sw_reset_i,
      .ghot_all_i, .ghot_ds_i, .local_hot_b_i, .local_hot_c_i, .boot_cfg_i, .port_a_o,
      .port_b_o, .port_c_o, .core_rst_o, .core_flush_o, .fund_active_o, .cold_o, .boot_cfg_o);
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // upstream port ignores downstream-only and local
   function automatic int ep(int a, int g, int d, int l);
      int x, y;
      x = a ? g : g | d;
      y = a ? g : g | d | l;
      return x * 40 + y * 6 + (a ? 0 : y);
   endfunction
   task automatic hot(int g, int d, int b, int c);
      @(negedge core_clk_i);
      {ghot_all_i, ghot_ds_i, local_hot_b_i, local_hot_c_i} = {g[0], d[0], b[0], c[0]};
      @(negedge core_clk_i);
      chk("port a", port_a_o, 16'(ep(1, g, d, 0)));
      chk("port b", port_b_o, 16'(ep(0, g, d, b)));
      chk("port c", port_c_o, 16'(ep(0, g, d, c)));
      chk("core", {core_rst_o, core_flush_o}, {g[0], d[0] & !g[0]});
   endtask
   task automatic wait_off();
      for (int i = 0; i < 40 && fund_active_o !== 1'b0; i++) @(negedge core_clk_i);
   endtask
   task automatic pin(logic c);
      @(negedge core_clk_i);
      req = 1'b1;
      local_hot_b_i = 1'b1;
      cfg = 16'($random(seed));
      repeat (6) @(negedge core_clk_i);
      chk("fund on", fund_active_o, 16'h0001);
      chk("refused", {port_b_o.hot_req, core_flush_o}, 16'h0000);
      req = 1'b0;
      local_hot_b_i = 1'b0;
      wait_off();
      chk("cold", cold_o, c);
      chk("boot", boot_cfg_o, cfg);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      pin(1'b1);
      $display("power-up test done");
      repeat (40) begin
         r = $random(seed);
         hot(r & 1, (r >> 1) & 1, (r >> 2) & 1, (r >> 3) & 1);
      end
      hot(0, 0, 0, 0);
      $display("hot test done");
      pin(1'b0);
      $display("warm pin test done");
      sw_reset_i = 1'b1;
      @(negedge core_clk_i);
      sw_reset_i = 1'b0;
      @(negedge core_clk_i);
      chk("sw fund", fund_active_o, 16'h0001);
      n = 1;
      while (n < 40 && fund_active_o === 1'b1) begin
         @(negedge core_clk_i);
         if (fund_active_o === 1'b1) n++;
      end
      chk("sw span", 16'(n), 16'(SW_CYC));
      chk("sw cold", cold_o, 16'h0000);
      chk("boot kept", boot_cfg_o, cfg);
      $display("sw test done");
      @(negedge core_clk_i);
      rst_n_i = 1'b0;
      @(negedge core_clk_i);
      chk("reset flags", {fund_active_o, cold_o, core_rst_o, core_flush_o}, 16'h000e);
      chk("reset port", port_c_o, 16'h003e);
      repeat (5) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      pin(1'b1);
      $display("second power-up test done");
      test_done();
   end
   initial begin
      #20000;
      bad_count++;
      test_done();
   end
endmodule
